//--- rtl/madc_pkg.sv
// Package: offsets, field positions, reset values and codes of the algorithm debug register
package madc_pkg;
    localparam logic [7:0]  ADDR_DEBUG_CONTROL = 8'hec;
    localparam logic [7:0]  ADDR_SECOND_DAC    = 8'hf6;
    localparam logic [31:0] RESET_DEBUG        = 32'h0000_0000;
    localparam int          POS_OVERRIDE       = 31;
    localparam int          POS_SPEED_HI       = 30;
    localparam int          POS_SPEED_LO       = 16;
    localparam int          POS_CLOSED_DIS     = 15;
    localparam int          POS_HOLD_ALIGN     = 14;
    localparam int          POS_HOLD_SLOW      = 13;
    localparam int          POS_HOLD_POSDET    = 12;
    localparam int          POS_HOLD_SPDDET    = 11;
    localparam int          POS_ANGLE_SRC      = 10;
    localparam int          POS_IQ_HI          = 9;
    localparam int          POS_IQ_LO          = 0;
    localparam logic [9:0]  IQ_POS_MAX         = 10'h1f4;
    localparam logic [9:0]  IQ_NEG_MIN         = 10'h200;
    localparam logic [9:0]  IQ_NEG_MAX         = 10'h3e8;
    localparam logic [10:0] IQ_WRAP            = 11'h400;
    localparam logic [8:0]  ANGLE_FULL         = 9'h168;
    typedef enum logic [1:0] {
        MADC_START_ALIGN  = 2'h0,
        MADC_START_DALIGN = 2'h1,
        MADC_START_SLOW   = 2'h2,
        MADC_START_POSDET = 2'h3
    } madc_startup_t;
endpackage : madc_pkg

//--- rtl/motor_algorithm_debug_control.sv
// Write-only algorithm debug control register and the controls it drives
`timescale 1ns/10ps
// Notes on behaviour
// - Override bit selects digital or analog speed
// - Digital speed field drives command under override
// - Bit 15 disables closed loop control
// - Bit 14 holds align for align startups
// - Bit 13 holds slow first cycle state
// - Bit 12 holds initial position detect state
// - Bit 11 holds initial speed detect state
// - Bit 10 selects align angle source
// - Bits 9..0 give torque current reference
// - Code maps to signed fraction over 500
// - Register resets to all zeros
// - Forced align angle applied modulo 360
module motor_algorithm_debug_control
    import madc_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic                regWrite,
    input  wire logic                regRead,
    input  wire logic [7:0]          regAddr,
    input  wire logic [31:0]         regWdata,
    output logic      [31:0]         regRdata,
    input  wire logic [14:0]         analogSpeed,
    input  wire logic [1:0]          startupMethod,
    input  wire logic                speedDetectEnable,
    input  wire logic                speedControlDisable,
    input  wire logic [8:0]          configAlignAngle,
    input  wire logic [8:0]          forcedAlignAngle,
    output logic      [14:0]         speedCommand,
    output logic                     closedControlDisable,
    output logic                     holdAlign,
    output logic                     holdSlowCycle,
    output logic                     holdPositionDetect,
    output logic                     holdSpeedDetect,
    output logic      [8:0]          alignAngle,
    output logic                     torqueCurrentValid,
    output logic signed [10:0]       torqueCurrentOverride
);
    logic [31:0]        debugControl;
    logic               fieldOverride;
    logic [14:0]        fieldSpeed;
    logic [9:0]         fieldIq;
    logic [8:0]         wrappedAngle;
    logic signed [10:0] next_torque;
    logic               next_valid;
    madc_startup_t      method;

    assign method        = madc_startup_t'(startupMethod);
    assign fieldOverride = debugControl[POS_OVERRIDE];
    assign fieldSpeed    = debugControl[POS_SPEED_HI:POS_SPEED_LO];
    assign fieldIq       = debugControl[POS_IQ_HI:POS_IQ_LO];

    // Fields take effect from the cycle after the write completes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            debugControl <= RESET_DEBUG;
        end else if (regWrite && regAddr == ADDR_DEBUG_CONTROL) begin
            debugControl <= regWdata;
        end
    end

    // Write-only: nothing leaks back, so software cannot mistake shadow for live state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdata <= 32'h0000_0000;
        end else if (regRead) begin
            regRdata <= 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            speedCommand <= 15'h0000;
        end else begin
            speedCommand <= fieldOverride ? fieldSpeed : analogSpeed;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            closedControlDisable <= 1'b0;
            holdAlign            <= 1'b0;
            holdSlowCycle        <= 1'b0;
            holdPositionDetect   <= 1'b0;
            holdSpeedDetect      <= 1'b0;
        end else begin
            closedControlDisable <= debugControl[POS_CLOSED_DIS];
            holdAlign            <= debugControl[POS_HOLD_ALIGN] &&
                                    (method == MADC_START_ALIGN ||
                                     method == MADC_START_DALIGN);
            holdSlowCycle        <= debugControl[POS_HOLD_SLOW] &&
                                    method == MADC_START_SLOW;
            holdPositionDetect   <= debugControl[POS_HOLD_POSDET] &&
                                    method == MADC_START_POSDET;
            holdSpeedDetect      <= debugControl[POS_HOLD_SPDDET] && speedDetectEnable;
        end
    end

    // Single subtraction suffices: a 9-bit value is below twice 360
    assign wrappedAngle = (forcedAlignAngle >= ANGLE_FULL) ?
                          forcedAlignAngle - ANGLE_FULL : forcedAlignAngle;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            alignAngle <= 9'h000;
        end else begin
            alignAngle <= debugControl[POS_ANGLE_SRC] ? wrappedAngle
                                                      : configAlignAngle;
        end
    end

    // Output is in units of 1/500 of the full reference current
    always_comb begin
        next_torque = 11'sh000;
        next_valid  = 1'b0;
        if (fieldIq <= IQ_POS_MAX) begin
            next_torque = signed'({1'b0, fieldIq});
            next_valid  = 1'b1;
        end else if (fieldIq >= IQ_NEG_MIN && fieldIq <= IQ_NEG_MAX) begin
            next_torque = signed'(11'({1'b0, fieldIq} - IQ_WRAP));
            next_valid  = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            torqueCurrentOverride <= 11'sh000;
            torqueCurrentValid    <= 1'b0;
        end else begin
            torqueCurrentOverride <= speedControlDisable ? next_torque : 11'sh000;
            torqueCurrentValid    <= speedControlDisable && next_valid;
        end
    end

    // A write to the debug register; its fields reach the outputs two edges later
    sequence seqDebugWrite;
        regWrite && regAddr == ADDR_DEBUG_CONTROL;
    endsequence
    sequence seqOverrideWrite;
        seqDebugWrite ##0 regWdata[POS_OVERRIDE];
    endsequence

    AST_SPEED_SRC: assert property (@(posedge clk) disable iff (!rst_b)
        $past(rst_b) |->
            speedCommand == ($past(debugControl[31]) ? $past(debugControl[30:16])
                                                     : $past(analogSpeed)))
        else $error("speed command source wrong");
    AST_WRITE_LANDS: assert property (@(posedge clk) disable iff (!rst_b)
        seqOverrideWrite |->
            ##2 speedCommand == $past(regWdata[POS_SPEED_HI:POS_SPEED_LO], 2))
        else $error("written speed not applied");
    AST_CLOSED: assert property (@(posedge clk) disable iff (!rst_b)
        seqDebugWrite |->
            ##2 closedControlDisable == $past(regWdata[POS_CLOSED_DIS], 2))
        else $error("closed loop disable wrong");
    AST_ALIGN: assert property (@(posedge clk) disable iff (!rst_b)
        holdAlign |-> $past(debugControl[14]) && !$past(startupMethod[1]))
        else $error("align hold without cause");
    AST_SLOW: assert property (@(posedge clk) disable iff (!rst_b)
        holdSlowCycle == ($past(debugControl[13]) && $past(startupMethod) == 2'h2))
        else $error("slow cycle hold wrong");
    AST_POS_DETECT: assert property (@(posedge clk) disable iff (!rst_b)
        holdPositionDetect == ($past(debugControl[12]) && $past(startupMethod) == 2'h3))
        else $error("position detect hold wrong");
    AST_SPEED_DETECT: assert property (@(posedge clk) disable iff (!rst_b)
        holdSpeedDetect == ($past(debugControl[11]) && $past(speedDetectEnable)))
        else $error("speed detect hold wrong");
    AST_ANGLE: assert property (@(posedge clk) disable iff (!rst_b)
        alignAngle < 9'h168 || !$past(debugControl[10]))
        else $error("forced angle not wrapped");
    AST_IQ_OFF: assert property (@(posedge clk) disable iff (!rst_b)
        !$past(speedControlDisable) |-> torqueCurrentOverride == 11'sh000 && !torqueCurrentValid)
        else $error("torque reference leaks while speed loop on");
    AST_IQ_NEG: assert property (@(posedge clk) disable iff (!rst_b)
        $past(speedControlDisable) && $past(debugControl[9:0]) == 10'h3e8 |->
            torqueCurrentOverride == -11'sd24)
        else $error("negative reference mapping wrong");
    AST_READ_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
        regRdata == 32'h0000_0000)
        else $error("write-only register read back data");

    // Just after reset is let go, the outputs still hold what reset gave them
    AST_RESET_VALUES: assert property (@(posedge clk) disable iff (!rst_b)
        !$past(rst_b) |->
            debugControl == RESET_DEBUG && speedCommand == 15'h0000 &&
            alignAngle == 9'h000 && !closedControlDisable && !holdAlign &&
            !torqueCurrentValid && torqueCurrentOverride == 11'sh000)
        else $error("output not at reset value after reset");

    // Writes elsewhere must leave the shadow untouched
    AST_OTHER_ADDR: assert property (@(posedge clk) disable iff (!rst_b)
        regWrite && regAddr != ADDR_DEBUG_CONTROL |=> debugControl == $past(debugControl))
        else $error("write to another address changed the register");

    AST_ALIGN_SET: assert property (@(posedge clk) disable iff (!rst_b)
        $past(rst_b) && $past(debugControl[POS_HOLD_ALIGN]) && !$past(startupMethod[1]) |->
            holdAlign)
        else $error("align hold missing");

    // Angle selection and wrap, checked as values rather than only as a range
    AST_ANGLE_CONFIG: assert property (@(posedge clk) disable iff (!rst_b)
        $past(rst_b) && !$past(debugControl[POS_ANGLE_SRC]) |->
            alignAngle == $past(configAlignAngle))
        else $error("configured align angle not selected");
    AST_ANGLE_FORCED: assert property (@(posedge clk) disable iff (!rst_b)
        $past(rst_b) && $past(debugControl[POS_ANGLE_SRC]) |->
            alignAngle == $past(forcedAlignAngle) % ANGLE_FULL)
        else $error("forced align angle not reduced modulo a full turn");

    // Code windows: the gap and the top end must never produce a reference
    AST_IQ_POS: assert property (@(posedge clk) disable iff (!rst_b)
        $past(rst_b) && $past(speedControlDisable) && $past(fieldIq) <= IQ_POS_MAX |->
            torqueCurrentValid && torqueCurrentOverride == $signed({1'b0, $past(fieldIq)}))
        else $error("positive reference mapping wrong");
    AST_IQ_REFUSED: assert property (@(posedge clk) disable iff (!rst_b)
        $past(rst_b) && (($past(fieldIq) > IQ_POS_MAX && $past(fieldIq) < IQ_NEG_MIN) ||
                         $past(fieldIq) > IQ_NEG_MAX) |->
            !torqueCurrentValid && torqueCurrentOverride == 11'sh000)
        else $error("refused reference code produced an output");
endmodule : motor_algorithm_debug_control

//--- bench/motor_algorithm_debug_control_test.sv
// Self-checking bench for the algorithm debug control register
`timescale 1ns/10ps
module motor_algorithm_debug_control_test;
    import madc_pkg::*;
    typedef struct {
        logic [31:0] wd;
        logic [1:0]  m;
        logic        sde;
        logic        scd;
        logic [14:0] sp;
        logic [4:0]  fl;
        logic [8:0]  ang;
        logic        v;
        logic [10:0] iq;
    } madc_row_t;
    logic clk = 1'b0, rst_b = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0000_0000;
    logic [14:0] analogSpeed = 15'h1234;
    logic [1:0]  startupMethod = 2'h0;
    logic        speedDetectEnable = 1'b0, speedControlDisable = 1'b0;
    logic [8:0]  configAlignAngle = 9'h05a;
    // 400 degrees, so the wrap to 40 is exercised
    logic [8:0]  forcedAlignAngle = 9'h190;
    logic [31:0] regRdata;
    logic [14:0] speedCommand;
    logic [8:0]  alignAngle;
    logic signed [10:0] torqueCurrentOverride;
    logic closedControlDisable, holdAlign, holdSlowCycle, holdPositionDetect;
    logic holdSpeedDetect, torqueCurrentValid;
    int   mismatches = 0, checkCount = 0;
    wire  [40:0] outs = {speedCommand, closedControlDisable, holdAlign, holdSlowCycle,
        holdPositionDetect, holdSpeedDetect, alignAngle, torqueCurrentValid,
        torqueCurrentOverride};
    madc_row_t rows[14] = '{
        '{32'h0000_0000, 2'h0, 1'b0, 1'b0, 15'h1234, 5'h00, 9'h05a, 1'b0, 11'h000},
        '{32'h8001_0000, 2'h0, 1'b0, 1'b0, 15'h0001, 5'h00, 9'h05a, 1'b0, 11'h000},
        '{32'h0000_fc00, 2'h1, 1'b1, 1'b0, 15'h1234, 5'h19, 9'h028, 1'b0, 11'h000},
        '{32'h7fff_21f4, 2'h2, 1'b0, 1'b1, 15'h1234, 5'h04, 9'h05a, 1'b1, 11'h1f4},
        '{32'h0000_1200, 2'h3, 1'b0, 1'b1, 15'h1234, 5'h02, 9'h05a, 1'b1, 11'h600},
        '{32'h0000_03e8, 2'h3, 1'b0, 1'b1, 15'h1234, 5'h00, 9'h05a, 1'b1, 11'h7e8},
        '{32'h0000_01f5, 2'h0, 1'b0, 1'b1, 15'h1234, 5'h00, 9'h05a, 1'b0, 11'h000},
        '{32'h0000_4800, 2'h2, 1'b0, 1'b0, 15'h1234, 5'h00, 9'h05a, 1'b0, 11'h000},
        '{32'h0000_01ff, 2'h0, 1'b0, 1'b1, 15'h1234, 5'h00, 9'h05a, 1'b0, 11'h000},
        '{32'h0000_03e9, 2'h0, 1'b0, 1'b1, 15'h1234, 5'h00, 9'h05a, 1'b0, 11'h000},
        '{32'h0000_0000, 2'h1, 1'b1, 1'b1, 15'h1234, 5'h00, 9'h05a, 1'b1, 11'h000},
        '{32'h0000_4000, 2'h0, 1'b0, 1'b0, 15'h1234, 5'h08, 9'h05a, 1'b0, 11'h000},
        '{32'h0000_01f4, 2'h0, 1'b0, 1'b0, 15'h1234, 5'h00, 9'h05a, 1'b0, 11'h000},
        '{32'hffff_0000, 2'h0, 1'b0, 1'b0, 15'h7fff, 5'h00, 9'h05a, 1'b0, 11'h000}};
    always #12.5 clk = ~clk;
    motor_algorithm_debug_control motor_algorithm_debug_control_i (
        .clk                   (clk),
        .rst_b                 (rst_b),
        .regWrite              (regWrite),
        .regRead               (regRead),
        .regAddr               (regAddr),
        .regWdata              (regWdata),
        .regRdata              (regRdata),
        .analogSpeed           (analogSpeed),
        .startupMethod         (startupMethod),
        .speedDetectEnable     (speedDetectEnable),
        .speedControlDisable   (speedControlDisable),
        .configAlignAngle      (configAlignAngle),
        .forcedAlignAngle      (forcedAlignAngle),
        .speedCommand          (speedCommand),
        .closedControlDisable  (closedControlDisable),
        .holdAlign             (holdAlign),
        .holdSlowCycle         (holdSlowCycle),
        .holdPositionDetect    (holdPositionDetect),
        .holdSpeedDetect       (holdSpeedDetect),
        .alignAngle            (alignAngle),
        .torqueCurrentValid    (torqueCurrentValid),
        .torqueCurrentOverride (torqueCurrentOverride)
    );
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checkCount++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Called at a falling edge; returns once dependent outputs have settled
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge clk);
        regWrite = 1'b0;
        @(negedge clk);
    endtask : wr
    task automatic summarize;
        $display("checks %0d mismatches %0d", checkCount, mismatches);
        if (mismatches == 0 && checkCount > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    initial begin
        #2000000;
        mismatches++;
        summarize();
    end
    initial begin
        repeat (3) @(negedge clk);
        chk(outs, 0);
        rst_b = 1'b1;
        foreach (rows[i]) begin
            startupMethod = rows[i].m;
            speedDetectEnable = rows[i].sde;
            speedControlDisable = rows[i].scd;
            wr(8'hec, rows[i].wd);
            chk(outs, {rows[i].sp, rows[i].fl, rows[i].ang, rows[i].v, rows[i].iq});
        end
        // Other addresses must leave the register alone
        wr(8'hf6, 32'h0000_fc00);
        chk(outs, {15'h7fff, 26'h005_a000});
        regRead = 1'b1;
        @(negedge clk);
        chk(regRdata, 0);
        regRead = 1'b0;
        wr(8'hec, 32'h0000_0000);
        analogSpeed = 15'h0abc;
        @(negedge clk);
        chk(speedCommand, 15'h0abc);
        // Back-to-back writes: only the last one should stick
        regAddr = 8'hec;
        regWdata = 32'h8005_0000;
        regWrite = 1'b1;
        @(negedge clk);
        regWdata = 32'h0000_8000;
        @(negedge clk);
        regWrite = 1'b0;
        @(negedge clk);
        chk({speedCommand, closedControlDisable}, {15'h0abc, 1'b1});
        rst_b = 1'b0;
        #1;
        chk(outs, 0);
        @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        chk(outs, {15'h0abc, 5'h00, 9'h05a, 12'h000});
        // Forced angle end points: exactly a full turn, just below it, the top code
        forcedAlignAngle = 9'h168;
        wr(8'hec, 32'h0000_0400);
        chk(alignAngle, 9'h000);
        forcedAlignAngle = 9'h167;
        @(negedge clk);
        chk(alignAngle, 9'h167);
        forcedAlignAngle = 9'h1ff;
        @(negedge clk);
        chk(alignAngle, 9'h097);
        configAlignAngle = 9'h0c8;
        wr(8'hec, 32'h0000_0000);
        chk(alignAngle, 9'h0c8);
        summarize();
    end
endmodule : motor_algorithm_debug_control_test
